// ===== rtl/pesd_edge_sync.sv
// Two-flop synchroniser with falling-edge detector
`timescale 1ns/100ps
module pesd_edge_sync (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  input  wire logic   en_i,
  input  wire logic   async_i,
  pesd_sync_if.src    sync
);
  import pesd_pkg::*;

  logic [1:0] sync_q;
  logic       last_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_q <= SYNC_RST;
      last_q <= 1'b1;
    end else if (en_i) begin
      sync_q <= {sync_q[0], async_i};
      last_q <= sync_q[1];
    end
  end

  // Edge looks only at the second stage and beyond
  assign sync.level = sync_q[1];
  assign sync.fall  = en_i & last_q & ~sync_q[1];
endmodule

// ===== rtl/pesd_pkg.sv
// Package with constants and types for the pack presence and emergency shutdown block
package pesd_pkg;

  localparam int unsigned CLK_FREQ_HZ        = 100_000_000;
  localparam int unsigned SYSTEM_PRESENT_N_INTERVAL_MS   = 1000;
  localparam int unsigned SYSTEM_PRESENT_N_INTERVAL_CYC  = (CLK_FREQ_HZ / 1000) * SYSTEM_PRESENT_N_INTERVAL_MS;
  localparam int unsigned OFF_TIMEOUT_MS     = 10_000;
  localparam int unsigned OFF_TIMEOUT_CYC    = (CLK_FREQ_HZ / 1000) * OFF_TIMEOUT_MS;
  localparam int unsigned TICK_CYC           = 100_000;
  localparam int unsigned TIMEOUT_W          = 16;
  localparam logic [TIMEOUT_W-1:0] OFF_TIMEOUT_TICKS_RST = 16'h2710;
  localparam logic [1:0]  SYNC_RST           = 2'h3;

  typedef enum logic [2:0] {
    PESD_ST_ON   = 3'b001,
    PESD_ST_OFF  = 3'b010,
    PESD_ST_FUSE = 3'b100
  } pesd_state_t;

endpackage

// ===== rtl/pesd_sync_if.sv
// Interface carrying a synchronised input and its falling-edge event
`timescale 1ns/100ps
interface pesd_sync_if;
  logic level;
  logic fall;
  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface

// ===== rtl/pesd_top.sv
// Pack presence sampling, emergency shutdown and fuse control
`timescale 1ns/100ps
module pesd_top #(
  parameter int unsigned SYSTEM_PRESENT_N_INTERVAL = pesd_pkg::SYSTEM_PRESENT_N_INTERVAL_CYC,
  parameter int unsigned TICK          = pesd_pkg::TICK_CYC
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_n_i,
  input  wire logic                           clk_en_i,
  input  wire logic                           system_present_n_i,
  input  wire logic                           emergency_off_n_i,
  input  wire logic [pesd_pkg::TIMEOUT_W-1:0] off_timeout_ticks_i,
  input  wire logic                           second_level_fault_i,
  input  wire logic                           temp_out_of_range_i,
  input  wire logic                           charge_request_i,
  input  wire logic                           discharge_request_i,
  output logic                                system_present_o,
  output logic                                charge_switch_o,
  output logic                                discharge_switch_o,
  output logic                                fuse_blow_o,
  output logic                                emergency_off_o,
  output logic                                charge_inhibit_o,
  output logic                                charge_suspend_o
);
  import pesd_pkg::*;

  pesd_sync_if off_sync ();

  pesd_edge_sync u_off_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .en_i    (clk_en_i),
    .async_i (emergency_off_n_i),
    .sync    (off_sync)
  );

  function automatic logic cnt_done(input logic [31:0] cnt, input int unsigned lim);
    cnt_done = (cnt >= 32'(lim - 1));
  endfunction

  logic [31:0]          system_present_n_cnt_q;
  logic [31:0]          tick_cnt_q;
  logic                 tick;
  logic [TIMEOUT_W-1:0] off_ticks_q;
  pesd_state_t          state_q;
  logic                 charging_q;

  // Presence sampled once per interval
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      system_present_n_cnt_q       <= '0;
      system_present_o <= 1'b0;
    end else if (clk_en_i) begin
      if (cnt_done(system_present_n_cnt_q, SYSTEM_PRESENT_N_INTERVAL)) begin
        system_present_n_cnt_q       <= '0;
        system_present_o <= ~system_present_n_i;
      end else begin
        system_present_n_cnt_q <= system_present_n_cnt_q + 32'h1;
      end
    end
  end

  // Free-running timebase for the shutdown timeout
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_cnt_q <= '0;
    end else if (clk_en_i) begin
      if (tick) begin
        tick_cnt_q <= '0;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h1;
      end
    end
  end
  assign tick = cnt_done(tick_cnt_q, TICK);

  // Switch control state machine; fuse state is terminal
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q     <= PESD_ST_ON;
      off_ticks_q <= '0;
    end else if (clk_en_i) begin
      case (state_q)
        PESD_ST_ON: begin
          if (second_level_fault_i) begin
            state_q <= PESD_ST_FUSE;
          end else if (off_sync.fall) begin
            state_q     <= PESD_ST_OFF;
            off_ticks_q <= '0;
          end
        end
        PESD_ST_OFF: begin
          if (second_level_fault_i) begin
            state_q <= PESD_ST_FUSE;
          end else if (off_sync.fall) begin
            state_q <= PESD_ST_ON;
          end else if (tick) begin
            if (off_ticks_q + TIMEOUT_W'(1) >= off_timeout_ticks_i) begin
              state_q <= PESD_ST_ON;
            end else begin
              off_ticks_q <= off_ticks_q + TIMEOUT_W'(1);
            end
          end
        end
        PESD_ST_FUSE: begin
          state_q <= PESD_ST_FUSE;
        end
        default: begin
          state_q <= PESD_ST_FUSE;
        end
      endcase
    end
  end

  // Tracks whether a charge is in progress; a charge cannot start while too hot or cold
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      charging_q <= 1'b0;
    end else if (clk_en_i) begin
      charging_q <= charge_request_i & (state_q == PESD_ST_ON)
                    & (charging_q | ~temp_out_of_range_i);
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      charge_switch_o    <= 1'b0;
      discharge_switch_o <= 1'b0;
      fuse_blow_o        <= 1'b0;
      emergency_off_o    <= 1'b0;
      charge_inhibit_o   <= 1'b0;
      charge_suspend_o   <= 1'b0;
    end else if (clk_en_i) begin
      // Both paths open together outside the on state
      charge_switch_o    <= (state_q == PESD_ST_ON) & charge_request_i
                            & ~temp_out_of_range_i;
      discharge_switch_o <= (state_q == PESD_ST_ON) & discharge_request_i;
      fuse_blow_o        <= (state_q == PESD_ST_FUSE);
      emergency_off_o    <= (state_q == PESD_ST_OFF);
      charge_inhibit_o   <= temp_out_of_range_i & charge_request_i & ~charging_q;
      charge_suspend_o   <= temp_out_of_range_i & charging_q;
    end
  end
endmodule

// ===== tb/pesd_host_model.sv
// Host system and maintenance button driving the presence and shutdown pins
`timescale 1ns/100ps
module pesd_host_model (
  input  wire logic clk_i,
  output logic      system_present_n_o,
  output logic      emergency_off_n_o
);
  initial begin
    system_present_n_o = 1'b1;
    emergency_off_n_o  = 1'b1;
  end
  task automatic attach(input logic on);
    @(posedge clk_i);
    #1 system_present_n_o = ~on;
  endtask
  // Held low several cycles, then released past the minimum spacing
  task automatic press();
    @(posedge clk_i);
    #1 emergency_off_n_o = 1'b0;
    repeat (6) @(posedge clk_i);
    #1 emergency_off_n_o = 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
  endtask
endmodule

// ===== tb/pesd_top_properties.sv
// Checker for presence, shutdown, fuse and temperature behaviour
`timescale 1ns/100ps
module pesd_chk (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic emergency_off_n_i,
  input  wire logic second_level_fault_i,
  input  wire logic temp_out_of_range_i,
  input  wire logic system_present_o,
  input  wire logic charge_switch_o,
  input  wire logic discharge_switch_o,
  input  wire logic fuse_blow_o,
  input  wire logic emergency_off_o,
  input  wire logic charge_suspend_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_SW_OFF: assert property (emergency_off_o |-> !charge_switch_o && !discharge_switch_o)
    else $error("switch on in shutdown");
  AST_ENTER: assert property ($fell(emergency_off_n_i) && !emergency_off_o && !fuse_blow_o
    |-> ##[3:5] emergency_off_o) else $error("no shutdown");
  AST_EXIT: assert property ($fell(emergency_off_n_i) && emergency_off_o
    |-> ##[3:5] !emergency_off_o) else $error("no restart");
  AST_EDGE: assert property ($rose(emergency_off_o) |->
    $past(emergency_off_n_i, 5) && !$past(emergency_off_n_i, 4))
    else $error("shutdown without edge");
  AST_FUSE_SET: assert property (second_level_fault_i |-> ##[1:3] fuse_blow_o)
    else $error("fuse not blown");
  AST_FUSE_HOLD: assert property (fuse_blow_o |=> fuse_blow_o)
    else $error("fuse released");
  AST_FUSE_OFF: assert property (fuse_blow_o |-> !charge_switch_o && !discharge_switch_o)
    else $error("switch on with fuse");
  AST_SUSP: assert property (charge_switch_o && temp_out_of_range_i
    |=> !charge_switch_o && charge_suspend_o) else $error("charge not suspended");
  AST_SYSTEM_PRESENT_N: assert property ($changed(system_present_o) |=> $stable(system_present_o)[*8])
    else $error("presence sampled too often");
endmodule
bind pesd_top pesd_chk CHK (.*);

// ===== tb/testbench.sv
// Self-checking bench for the presence and emergency shutdown block
`timescale 1ns/100ps
module testbench;
  import pesd_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, second_level_fault_i = 1'b0;
  logic temp_out_of_range_i = 1'b0, charge_request_i = 1'b1, discharge_request_i = 1'b1;
  logic [TIMEOUT_W-1:0] off_timeout_ticks_i = 16'hFFFF;
  logic system_present_n_i, emergency_off_n_i, system_present_o, charge_switch_o;
  logic discharge_switch_o, fuse_blow_o, emergency_off_o, charge_inhibit_o, charge_suspend_o;
  int error_cnt = 0;
  int checks = 0;
  always #5 clk_i = ~clk_i;
  pesd_top #(.SYSTEM_PRESENT_N_INTERVAL(100), .TICK(10)) DUT (.*);
  pesd_host_model HOST (.clk_i(clk_i), .system_present_n_o(system_present_n_i),
    .emergency_off_n_o(emergency_off_n_i));
  task automatic chk(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Bounded wait on presence (s=0) or shutdown (s=1) output
  task automatic wt(input int s, input logic v, input int n);
    logic g;
    repeat (n) begin
      cy(1);
      g = s ? emergency_off_o : system_present_o;
      if (g === v) return;
    end
    chk("wait", 1'b1, 1'b0);
    summarize();
  endtask
  task automatic t_system_present_n();
    HOST.attach(1'b1);
    wt(0, 1'b1, 220);
    HOST.attach(1'b0);
    cy(50);
    chk("present held", 1'b1, system_present_o);
    wt(0, 1'b0, 120);
  endtask
  task automatic t_shut();
    chk("chg on", 1'b1, charge_switch_o);
    HOST.press();
    chk("off", 1'b1, emergency_off_o);
    chk("chg off", 1'b0, charge_switch_o);
    chk("dsg off", 1'b0, discharge_switch_o);
    HOST.press();
    chk("dsg back", 1'b1, discharge_switch_o);
  endtask
  task automatic t_tmo();
    off_timeout_ticks_i = 16'h0003;
    HOST.press();
    chk("tmo off", 1'b1, emergency_off_o);
    cy(10);
    chk("tmo early", 1'b1, emergency_off_o);
    wt(1, 1'b0, 15);
    cy(1);
    chk("tmo dsg", 1'b1, discharge_switch_o);
    off_timeout_ticks_i = 16'hFFFF;
  endtask
  task automatic t_temp();
    temp_out_of_range_i = 1'b1;
    cy(3);
    chk("temp chg", 1'b0, charge_switch_o);
    chk("suspend", 1'b1, charge_suspend_o);
    chk("temp dsg", 1'b1, discharge_switch_o);
    charge_request_i = 1'b0;
    cy(2);
    charge_request_i = 1'b1;
    cy(3);
    chk("inhibit", 1'b1, charge_inhibit_o);
    chk("no suspend", 1'b0, charge_suspend_o);
    chk("inhibit chg", 1'b0, charge_switch_o);
    temp_out_of_range_i = 1'b0;
    cy(3);
    chk("temp ok chg", 1'b1, charge_switch_o);
    chk("inhibit gone", 1'b0, charge_inhibit_o);
  endtask
  // Clock enable low must freeze the charge switch output
  task automatic t_freeze();
    clk_en_i = 1'b0;
    charge_request_i = 1'b0;
    cy(4);
    chk("frozen chg", 1'b1, charge_switch_o);
    clk_en_i = 1'b1;
    cy(2);
    chk("thawed chg", 1'b0, charge_switch_o);
    charge_request_i = 1'b1;
    cy(2);
  endtask
  // Fuse state lasts until reset only
  task automatic t_reset();
    rst_n_i = 1'b0;
    cy(2);
    rst_n_i = 1'b1;
    cy(2);
    chk("fuse cleared", 1'b0, fuse_blow_o);
    chk("dsg after reset", 1'b1, discharge_switch_o);
  endtask
  task automatic t_fuse();
    second_level_fault_i = 1'b1;
    cy(4);
    second_level_fault_i = 1'b0;
    chk("fuse", 1'b1, fuse_blow_o);
    HOST.press();
    chk("fuse off", 1'b0, emergency_off_o);
    chk("fuse dsg", 1'b0, discharge_switch_o);
  endtask
  initial begin
    cy(10);
    rst_n_i = 1'b1;
    cy(3);
    t_system_present_n();
    t_shut();
    t_tmo();
    t_temp();
    t_freeze();
    t_fuse();
    t_reset();
    summarize();
  end
endmodule
